// ==== hdl/relay_regs.svh ====
`ifndef RELAY_REGS_SVH
`define RELAY_REGS_SVH
// time base derived from the 20 MHz clock
`define CLK_HZ          20000000
`define TICK_10MS_US    10000
`define TICK_10MS_CYC   (`CLK_HZ / 1000000 * `TICK_10MS_US)
`define TICKS_PER_SEC   7'd100
// setting ranges
`define PULSE_W_MAX     7'd99
`define DELAY_S_MAX     7'd99
`define SCALE_MAX       20'd999999
`define SETPOINT_MAX    14'd9999
// reset value of the pending pulse count held by each channel
`define PEND_RST        20'h00000
`endif

// ==== hdl/relay_pkg.sv ====
package relay_pkg;
  typedef enum logic [2:0] {
    total_pulse_repeat_fn = 3'h0,
    low_rate_alarm_fn     = 3'h1,
    high_rate_alarm_fn    = 3'h2,
    window_rate_alarm_fn  = 3'h3,
    low_speed_alarm_fn    = 3'h4,
    high_speed_alarm_fn   = 3'h5,
    window_speed_alarm_fn = 3'h6,
    cal_weight_fn         = 3'h7
  } relay_fn_t;
endpackage

// ==== hdl/relay_cfg_if.sv ====
`timescale 1ns/1ns
// per-relay settings and shared measurements passed to one channel
interface relay_cfg_if;
  relay_pkg::relay_fn_t fn;
  logic                 enable;
  logic                 nc_logic;
  logic [6:0]           pulse_w;
  logic [19:0]          scale;
  logic [13:0]          low_sp;
  logic [13:0]          high_sp;
  logic [6:0]           delay_s;
  logic [13:0]          rate;
  logic [13:0]          speed;
  logic                 total_inc;
  logic                 cal_lower;
  logic                 tick_10ms;
  logic                 tick_1s;
  modport top (output fn, enable, nc_logic, pulse_w, scale, low_sp, high_sp, delay_s,
               rate, speed, total_inc, cal_lower, tick_10ms, tick_1s);
  modport chan (input fn, enable, nc_logic, pulse_w, scale, low_sp, high_sp, delay_s,
                rate, speed, total_inc, cal_lower, tick_10ms, tick_1s);
endinterface

// ==== hdl/relay_channel.sv ====
`timescale 1ns/1ns
`include "relay_regs.svh"
module relay_channel (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   ce_i,
  relay_cfg_if.chan   cfg,
  output logic        contact_o,
  output logic        active_o
);
  logic [19:0] scale_cnt;
  logic [19:0] pend;
  logic [6:0]  width_cnt;
  logic        pulsing;
  logic [6:0]  delay_cnt;
  logic        alarm_on;
  logic        low_cond;
  logic        high_cond;
  logic        cond;
  logic [13:0] mon;
  logic        is_alarm;
  logic        fn_true;
  logic        scale_hit;

  // speed alarms watch speed, the rest watch rate
  assign mon = (cfg.fn inside {relay_pkg::low_speed_alarm_fn, relay_pkg::high_speed_alarm_fn,
                relay_pkg::window_speed_alarm_fn}) ? cfg.speed : cfg.rate;
  assign low_cond  = mon < cfg.low_sp;
  assign high_cond = mon > cfg.high_sp;
  always_comb
  begin
    unique case (cfg.fn)
      relay_pkg::low_rate_alarm_fn, relay_pkg::low_speed_alarm_fn:       cond = low_cond;
      relay_pkg::high_rate_alarm_fn, relay_pkg::high_speed_alarm_fn:     cond = high_cond;
      relay_pkg::window_rate_alarm_fn, relay_pkg::window_speed_alarm_fn:
        cond = low_cond | high_cond;
      relay_pkg::total_pulse_repeat_fn, relay_pkg::cal_weight_fn:        cond = 1'b0;
    endcase
  end
  assign is_alarm = cfg.enable && cond;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      delay_cnt <= 7'h00;
      alarm_on  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!is_alarm)
      begin
        delay_cnt <= 7'h00;
        alarm_on  <= 1'b0;
      end
      else if (delay_cnt >= cfg.delay_s)
        alarm_on <= 1'b1;
      else if (cfg.tick_1s)
        delay_cnt <= delay_cnt + 7'h01;
    end
  end

  assign scale_hit = cfg.total_inc && (scale_cnt + 20'h00001 >= cfg.scale);
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      scale_cnt <= 20'h00000;
    else if (ce_i && cfg.fn == relay_pkg::total_pulse_repeat_fn && cfg.enable && cfg.total_inc)
      scale_cnt <= scale_hit ? 20'h00000 : scale_cnt + 20'h00001;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pend      <= `PEND_RST;
      pulsing   <= 1'b0;
      width_cnt <= 7'h00;
    end
    else if (ce_i)
    begin
      if (!pulsing && pend != 20'h00000)
      begin
        pulsing   <= 1'b1;
        width_cnt <= 7'h00;
        pend      <= pend - 20'h00001 +
                     {19'h0, scale_hit && cfg.fn == relay_pkg::total_pulse_repeat_fn
                      && cfg.enable};
      end
      else
      begin
        if (scale_hit && cfg.fn == relay_pkg::total_pulse_repeat_fn && cfg.enable)
          pend <= pend + 20'h00001;
        if (pulsing && cfg.tick_10ms)
        begin
          if (width_cnt + 7'h01 >= cfg.pulse_w)
            pulsing <= 1'b0;
          else
            width_cnt <= width_cnt + 7'h01;
        end
      end
    end
  end

  always_comb
  begin
    unique case (cfg.fn)
      relay_pkg::total_pulse_repeat_fn: fn_true = pulsing;
      relay_pkg::cal_weight_fn:         fn_true = cfg.cal_lower;
      default:                          fn_true = alarm_on;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      contact_o <= 1'b0;
      active_o  <= 1'b0;
    end
    else if (ce_i && cfg.enable)
    begin
      active_o  <= fn_true;
      contact_o <= fn_true ^ cfg.nc_logic;
    end
  end

  delay_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(alarm_on) |-> $past(is_alarm)) else $error("alarm rose without condition");
  clear_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !is_alarm) |=> !alarm_on && delay_cnt == 7'h00) else $error("alarm held");
  freeze_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !cfg.enable |=> $stable(contact_o)) else $error("contact moved while disabled");
  polarity_rel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    contact_o == (active_o ^ $past(cfg.nc_logic)) || !$past(cfg.enable) || !$past(ce_i))
    else $error("polarity wrong");
  alarm_en_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    alarm_on |-> $past(cfg.enable) || !$past(ce_i)) else $error("alarm while disabled");
  low_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && cfg.enable && cfg.fn == relay_pkg::low_rate_alarm_fn && cfg.rate < cfg.low_sp
     && cfg.delay_s == 7'h00) |=> alarm_on) else $error("low alarm missed");
  high_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && cfg.fn == relay_pkg::high_rate_alarm_fn && cfg.rate <= cfg.high_sp)
    |=> !alarm_on) else $error("high alarm false");
  pulse_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !pulsing && pend != 20'h00000) |=> pulsing) else $error("pulse lost");
endmodule

// ==== hdl/relay_outputs.sv ====
`timescale 1ns/1ns
`include "relay_regs.svh"
// Behaviour
// - Each relay selects pulse repeater, rate/speed alarms, or calibration weight drive.
// - Two relays with independent, identical setting sets.
// - Disabled relay holds its contact in its last state.
// - Normally-open closes when true; normally-closed opens when true.
// - Pulse width programmable 0.01 to 0.99 seconds in hundredths.
// - Pulse width limits achievable pulse rate.
// - One pulse per N total counts, N from 1 to 999999.
// - Low setpoint 0 to 9999 compared with rate or speed.
// - High setpoint 0 to 9999 compared with rate or speed.
// - Alarm acts only when selected and relay enabled.
// - Contact actuates after 0 to 99 second delay.
// - Low alarm while value below low setpoint, persisting for delay.
// - High alarm while value above high setpoint, persisting for delay.
// - Window alarms use both setpoints; single alarms use one.
// - Calibration function drives weight lower and raise; the contact here follows cal_lower only, with no raise drive.
module relay_outputs (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  input  wire relay_pkg::relay_fn_t fn_i [2],
  input  wire logic [1:0]           enable_i,
  input  wire logic [1:0]           nc_logic_i,
  input  wire logic [6:0]           pulse_w_i [2],
  input  wire logic [19:0]          scale_i [2],
  input  wire logic [13:0]          low_sp_i [2],
  input  wire logic [13:0]          high_sp_i [2],
  input  wire logic [6:0]           delay_s_i [2],
  input  wire logic [13:0]          rate_i,
  input  wire logic [13:0]          speed_i,
  input  wire logic                 total_inc_i,
  input  wire logic                 cal_lower_i,
  output logic [1:0]                contact_o,
  output logic [1:0]                active_o
);
  // wide enough for the full 10 ms count at 20 MHz; a narrower counter would wrap early
  logic [17:0] div_cnt;
  logic [6:0]  hund_cnt;
  logic        tick_10ms;
  logic        tick_1s;

  // shared 10 ms and 1 s time base, counts cycles not wall time
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt  <= 18'h00000;
      hund_cnt <= 7'h00;
    end
    else if (ce_i)
    begin
      if (tick_10ms)
      begin
        div_cnt  <= 18'h00000;
        hund_cnt <= tick_1s ? 7'h00 : hund_cnt + 7'h01;
      end
      else
        div_cnt <= div_cnt + 18'h00001;
    end
  end
  assign tick_10ms = div_cnt == 18'(`TICK_10MS_CYC - 1);
  assign tick_1s   = tick_10ms && (hund_cnt == `TICKS_PER_SEC - 7'h01);

  generate
    for (genvar g = 0; g < 2; g++)
    begin : gen_relay
      relay_cfg_if cfg ();
      // low setpoint clipped; high setpoint clipped
      assign cfg.fn        = fn_i[g];
      assign cfg.enable    = enable_i[g];
      assign cfg.nc_logic  = nc_logic_i[g];
      assign cfg.pulse_w   = (pulse_w_i[g] > `PULSE_W_MAX) ? `PULSE_W_MAX : pulse_w_i[g];
      assign cfg.scale     = (scale_i[g] > `SCALE_MAX) ? `SCALE_MAX : scale_i[g];
      assign cfg.low_sp    = (low_sp_i[g] > `SETPOINT_MAX) ? `SETPOINT_MAX : low_sp_i[g];
      assign cfg.high_sp   = (high_sp_i[g] > `SETPOINT_MAX) ? `SETPOINT_MAX : high_sp_i[g];
      assign cfg.delay_s   = (delay_s_i[g] > `DELAY_S_MAX) ? `DELAY_S_MAX : delay_s_i[g];
      assign cfg.rate      = rate_i;
      assign cfg.speed     = speed_i;
      assign cfg.total_inc = total_inc_i;
      assign cfg.cal_lower = cal_lower_i;
      assign cfg.tick_10ms = tick_10ms;
      assign cfg.tick_1s   = tick_1s;
      relay_channel u_chan (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .cfg       (cfg),
        .contact_o (contact_o[g]),
        .active_o  (active_o[g])
      );
    end
  endgenerate

  tick_space_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick_10ms |=> !tick_10ms) else $error("tick too close");
endmodule

// ==== tb/plant_relays.sv ====
`timescale 1ns/1ns
// plant input card: counts open-to-closed edges on each relay's wiring
module plant_relays (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] contact_i,
  output logic [7:0]      closes_o [2]
);
  logic [1:0] last;
  // the card only sees settled contact levels, so one edge is one closure
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      last        <= 2'h0;
      closes_o[0] <= 8'h00;
      closes_o[1] <= 8'h00;
    end
    else
    begin
      last <= contact_i;
      for (int r = 0; r < 2; r++)
        if (contact_i[r] && !last[r])
          closes_o[r] <= closes_o[r] + 8'h01;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [1:0] c; logic [1:0] a; logic ua;} note_t;
  logic                 clk_i, rst_n_i, ce, total_inc, cal_lower, chk;
  relay_pkg::relay_fn_t fn [2];
  logic [1:0]           en, nc, c_o, a_o;
  logic [6:0]           pw [2], dly [2];
  logic [19:0]          sc [2];
  logic [13:0]          lo [2], hi [2], rate, speed;
  logic [7:0]           closes [2];
  note_t                notes [$];
  note_t                n;
  int                   n_mismatch, tests_run, seed, cyc;

  relay_outputs DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .fn_i(fn), .enable_i(en),
    .nc_logic_i(nc), .pulse_w_i(pw), .scale_i(sc), .low_sp_i(lo), .high_sp_i(hi),
    .delay_s_i(dly), .rate_i(rate), .speed_i(speed), .total_inc_i(total_inc),
    .cal_lower_i(cal_lower), .contact_o(c_o), .active_o(a_o));
  plant_relays plant (.clk_i(clk_i), .rst_n_i(rst_n_i), .contact_i(c_o), .closes_o(closes));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic cmp(input string nm, input logic [1:0] e, input logic [1:0] s);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // the note is checked one edge later against the outputs standing then
  task automatic note(input logic [1:0] c, input logic [1:0] a, input logic ua);
    notes.push_back('{c, a, ua});
    chk <= 1'b1;
    @(posedge clk_i);
    chk <= 1'b0;
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task automatic inc();
    total_inc <= 1'b1;
    @(posedge clk_i);
    total_inc <= 1'b0;
    @(posedge clk_i);
  endtask

  // equality with a setpoint is not an alarm on either side
  function automatic logic alarm(relay_pkg::relay_fn_t f, logic [13:0] r, s, l, h);
    logic [13:0] v;
    v = (f >= relay_pkg::low_speed_alarm_fn) ? s : r;
    case (f)
      relay_pkg::low_rate_alarm_fn, relay_pkg::low_speed_alarm_fn: return v < l;
      relay_pkg::high_rate_alarm_fn, relay_pkg::high_speed_alarm_fn: return v > h;
      default: return (v < l) || (v > h);
    endcase
  endfunction

  // monitor: takes the oldest note whenever a result is flagged
  always @(posedge clk_i)
  begin
    cyc++;
    if (chk === 1'b1 && notes.size() > 0)
    begin
      n = notes.pop_front();
      cmp("contact", n.c, c_o);
      if (n.ua)
        cmp("active", n.a, a_o);
    end
    if (cyc == 3000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  initial
  begin
    logic [13:0]          l [2], h [2], rv, sv;
    relay_pkg::relay_fn_t f [2];
    logic [1:0]           ea, pn;
    logic [7:0]           b0;
    seed = 12715;
    {rst_n_i, total_inc, cal_lower, chk, rate, speed} = '0;
    {ce, en, nc} = 5'h1c;
    for (int r = 0; r < 2; r++)
    begin
      fn[r] = relay_pkg::low_rate_alarm_fn;
      {pw[r], dly[r], sc[r], lo[r], hi[r]} = {7'h01, 7'h00, 20'h00001, 14'h0000, 14'h270f};
    end
    wt(10);
    rst_n_i <= 1'b1;
    wt(2);
    for (int i = 0; i < 40; i++)
    begin
      pn = 2'($random(seed));
      rv = 14'($unsigned($random(seed)) % 10000);
      sv = 14'($unsigned($random(seed)) % 10000);
      for (int r = 0; r < 2; r++)
      begin
        f[r] = relay_pkg::relay_fn_t'(3'(1 + (i + 3 * r) % 6));
        l[r] = 14'($unsigned($random(seed)) % 10000);
        h[r] = 14'($unsigned($random(seed)) % 10000);
        ea[r] = alarm(f[r], (i % 5 == 0) ? l[r] : rv, (i % 7 == 0) ? h[r] : sv, l[r], h[r]);
        {fn[r], lo[r], hi[r]} <= {f[r], l[r], h[r]};
      end
      rate <= (i % 5 == 0) ? l[0] : rv;
      speed <= (i % 7 == 0) ? h[0] : sv;
      nc <= pn;
      wt(4);
      if (i % 5 != 0 && i % 7 != 0)
        note(ea ^ pn, ea, 1'b1);
    end
    $display("alarm functions done");
    fn <= '{relay_pkg::cal_weight_fn, relay_pkg::cal_weight_fn};
    nc <= 2'h0;
    for (int k = 0; k < 2; k++)
    begin
      cal_lower <= k[0];
      wt(4);
      note({2{k[0]}}, {2{k[0]}}, 1'b1);
    end
    $display("calibration weight done");
    fn <= '{relay_pkg::low_rate_alarm_fn, relay_pkg::low_rate_alarm_fn};
    {lo[0], lo[1], rate, nc} <= {14'h0064, 14'h0064, 14'h0032, 2'h1};
    wt(4);
    note(2'h2, 2'h3, 1'b1);
    en <= 2'h1;
    rate <= 14'h00c8;
    wt(4);
    note(2'h3, 2'h2, 1'b1);
    ce <= 1'b0;
    rate <= 14'h0032;
    wt(4);
    note(2'h3, 2'h2, 1'b1);
    {ce, en, nc, rate} <= {1'b1, 2'h3, 2'h0, 14'h00c8};
    dly[0] <= 7'h05;
    wt(4);
    rate <= 14'h0032;
    wt(40);
    note(2'h2, 2'h0, 1'b0);
    $display("enable and delay done");
    fn <= '{relay_pkg::total_pulse_repeat_fn, relay_pkg::total_pulse_repeat_fn};
    sc[0] <= 20'h00003;
    wt(4);
    b0 = closes[0];
    inc();
    wt(3);
    note(2'h2, 2'h2, 1'b1);
    inc();
    inc();
    wt(3);
    note(2'h3, 2'h3, 1'b1);
    cmp("closures", 2'h1, 2'(closes[0] - b0));
    $display("pulse repeater done");
    wt(2);
    end_sim();
  end
endmodule
